//--- verilog/mitd_core.sv
// instruction fetch, timing sequencer and data pointer/stack registers
// assumes program bytes arrive from code memory in the same cycle as
// their address; special-function access comes from the core datapath
`timescale 1ns/1ps
module mitd_core (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic [7:0] code_data,
    input wire logic branch_cond,
    input wire logic [1:0] bank_select,
    input wire logic [7:0] ind_reg_value,
    input wire logic sfr_wr,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    output logic [15:0] code_addr,
    output logic [7:0] sfr_rdata,
    output logic [15:0] data_pointer16,
    output logic [7:0] stack_pointer,
    output logic [7:0] opcode_out,
    output logic instr_done,
    output logic [7:0] ram_addr,
    output logic ram_sel,
    output logic sfr_sel,
    output logic bit_clear,
    output logic [7:0] bit_addr
);
    mitd_pkg::mitd_state_t state_r, state_nxt;
    logic [15:0] pc_r, pc_nxt;
    logic [7:0] op_r, op_nxt;
    logic [7:0] b1_r, b1_nxt;
    logic [7:0] b2_r, b2_nxt;
    logic [1:0] got_r, got_nxt;
    logic [2:0] cnt_r, cnt_nxt;
    logic [7:0] dpl_r, dpl_nxt;
    logic [7:0] dph_r, dph_nxt;
    logic [7:0] sp_r, sp_nxt;
    logic done_r, done_nxt;
    logic [7:0] ram_addr_r, ram_addr_nxt;
    logic ram_sel_r, ram_sel_nxt;
    logic sfr_sel_r, sfr_sel_nxt;
    logic clr_r, clr_nxt;
    logic [7:0] sfr_rdata_r, sfr_rdata_nxt;
    logic [1:0] n_bytes;
    logic [2:0] cyc_base;
    mitd_pkg::mitd_kind_t kind;
    logic uses_bank;
    logic uses_ind;
    logic [15:0] rel_target;
    logic [15:0] page_target;
    logic [15:0] long_target;
    logic [7:0] direct_addr;

    mitd_decode u_decode (
        .opcode(op_r),
        .n_bytes(n_bytes),
        .cyc_base(cyc_base),
        .kind(kind),
        .uses_bank(uses_bank),
        .uses_ind(uses_ind)
    );

    mitd_target u_target (
        .next_pc(pc_r),
        .rel_off((n_bytes == 2'd3) ? b2_r : b1_r),
        .page_bits({op_r[7:5], b1_r}),
        .long_addr({b1_r, b2_r}),
        .rel_target(rel_target),
        .page_target(page_target),
        .long_target(long_target)
    );

    assign direct_addr = b1_r;

    always_comb begin
        state_nxt = state_r;
        pc_nxt = pc_r;
        op_nxt = op_r;
        b1_nxt = b1_r;
        b2_nxt = b2_r;
        got_nxt = got_r;
        cnt_nxt = cnt_r;
        dpl_nxt = dpl_r;
        dph_nxt = dph_r;
        sp_nxt = sp_r;
        done_nxt = 1'b0;
        clr_nxt = 1'b0;
        ram_addr_nxt = ram_addr_r;
        ram_sel_nxt = ram_sel_r;
        sfr_sel_nxt = sfr_sel_r;
        sfr_rdata_nxt = 8'h00;
        case (sfr_addr)
            mitd_pkg::MITD_ADDR_DP_LOW: sfr_rdata_nxt = dpl_r;
            mitd_pkg::MITD_ADDR_DP_HIGH: sfr_rdata_nxt = dph_r;
            mitd_pkg::MITD_ADDR_STACK: sfr_rdata_nxt = sp_r;
            default: sfr_rdata_nxt = 8'h00;
        endcase
        if (sfr_wr) begin
            case (sfr_addr)
                mitd_pkg::MITD_ADDR_DP_LOW: dpl_nxt = sfr_wdata;
                mitd_pkg::MITD_ADDR_DP_HIGH: dph_nxt = sfr_wdata;
                mitd_pkg::MITD_ADDR_STACK: sp_nxt = sfr_wdata;
                default: ;
            endcase
        end
        case (state_r)
            mitd_pkg::MITD_S_FETCH: begin
                op_nxt = code_data;
                pc_nxt = pc_r + 16'h0001;
                got_nxt = 2'd1;
                cnt_nxt = 3'd1;
                state_nxt = mitd_pkg::MITD_S_OPER;
            end
            mitd_pkg::MITD_S_OPER: begin
                if (got_r < n_bytes) begin
                    if (got_r == 2'd1) begin
                        b1_nxt = code_data;
                    end else begin
                        b2_nxt = code_data;
                    end
                    pc_nxt = pc_r + 16'h0001;
                    got_nxt = got_r + 2'd1;
                    cnt_nxt = cnt_r + 3'd1;
                end else begin
                    // operand addressing for the datapath
                    if (uses_ind) begin
                        ram_addr_nxt = ind_reg_value;
                        ram_sel_nxt = 1'b1;
                        sfr_sel_nxt = 1'b0;
                    end else if (uses_bank) begin
                        ram_addr_nxt = {3'b000, bank_select,
                                        op_r[2:0]};
                        ram_sel_nxt = 1'b1;
                        sfr_sel_nxt = 1'b0;
                    end else begin
                        ram_addr_nxt = direct_addr;
                        ram_sel_nxt = (direct_addr <
                                       mitd_pkg::MITD_SFR_BASE);
                        sfr_sel_nxt = (direct_addr >=
                                       mitd_pkg::MITD_SFR_BASE);
                    end
                    state_nxt = mitd_pkg::MITD_S_WAIT;
                end
            end
            mitd_pkg::MITD_S_WAIT: begin
                if (cnt_r >= cyc_base + ((kind == mitd_pkg::MITD_K_COND ||
                    kind == mitd_pkg::MITD_K_BITCLR) && branch_cond
                    ? 3'd1 : 3'd0)) begin
                    done_nxt = 1'b1;
                    state_nxt = mitd_pkg::MITD_S_FETCH;
                    case (kind)
                        mitd_pkg::MITD_K_COND:
                            if (branch_cond) pc_nxt = rel_target;
                        mitd_pkg::MITD_K_BITCLR:
                            if (branch_cond) begin
                                pc_nxt = rel_target;
                                clr_nxt = 1'b1;
                            end
                        mitd_pkg::MITD_K_REL: pc_nxt = rel_target;
                        mitd_pkg::MITD_K_PAGE: begin
                            pc_nxt = page_target;
                            if (op_r[4]) sp_nxt = sp_r + 8'h02;
                        end
                        mitd_pkg::MITD_K_LONG: begin
                            pc_nxt = long_target;
                            if (op_r[4]) sp_nxt = sp_r + 8'h02;
                        end
                        mitd_pkg::MITD_K_RET: sp_nxt = sp_r - 8'h02;
                        mitd_pkg::MITD_K_DPJMP: pc_nxt = {dph_r, dpl_r};
                        mitd_pkg::MITD_K_DPLOAD: begin
                            dph_nxt = b1_r;
                            dpl_nxt = b2_r;
                        end
                        mitd_pkg::MITD_K_PUSH: begin
                            sp_nxt = sp_r + 8'h01;
                            ram_addr_nxt = sp_r + 8'h01;
                        end
                        mitd_pkg::MITD_K_POP: begin
                            sp_nxt = sp_r - 8'h01;
                            ram_addr_nxt = sp_r;
                        end
                        default: ;
                    endcase
                end else begin
                    cnt_nxt = cnt_r + 3'd1;
                end
            end
            default: state_nxt = mitd_pkg::MITD_S_FETCH;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            state_r <= mitd_pkg::MITD_S_FETCH;
            pc_r <= 16'h0000;
            op_r <= 8'h00;
            b1_r <= 8'h00;
            b2_r <= 8'h00;
            got_r <= 2'd0;
            cnt_r <= 3'd0;
            dpl_r <= mitd_pkg::MITD_RST_DP;
            dph_r <= mitd_pkg::MITD_RST_DP;
            sp_r <= mitd_pkg::MITD_RST_STACK;
            done_r <= 1'b0;
            clr_r <= 1'b0;
            ram_addr_r <= 8'h00;
            ram_sel_r <= 1'b0;
            sfr_sel_r <= 1'b0;
            sfr_rdata_r <= 8'h00;
        end else begin
            state_r <= state_nxt;
            pc_r <= pc_nxt;
            op_r <= op_nxt;
            b1_r <= b1_nxt;
            b2_r <= b2_nxt;
            got_r <= got_nxt;
            cnt_r <= cnt_nxt;
            dpl_r <= dpl_nxt;
            dph_r <= dph_nxt;
            sp_r <= sp_nxt;
            done_r <= done_nxt;
            clr_r <= clr_nxt;
            ram_addr_r <= ram_addr_nxt;
            ram_sel_r <= ram_sel_nxt;
            sfr_sel_r <= sfr_sel_nxt;
            sfr_rdata_r <= sfr_rdata_nxt;
        end
    end

    assign code_addr = pc_r;
    assign sfr_rdata = sfr_rdata_r;
    assign data_pointer16 = {dph_r, dpl_r};
    assign stack_pointer = sp_r;
    assign opcode_out = op_r;
    assign instr_done = done_r;
    assign ram_addr = ram_addr_r;
    assign ram_sel = ram_sel_r;
    assign sfr_sel = sfr_sel_r;
    assign bit_clear = clr_r;
    assign bit_addr = b1_r;
endmodule // mitd_core

//--- verilog/mitd_pkg.sv
// constants shared by the instruction timing and decode block
// assumes one 50 MHz core clock and a synchronous active-low reset
// Function
// - relative target is next instruction address plus signed 8-bit offset
// - direct address below 0x80 is data RAM, 0x80 and above is special-function space
// - page target replaces low 11 bits of next address, same 2 kB page
// - long call and jump load a full 16-bit target
// - opcode 0xa5 behaves as a one-byte, one-cycle no-operation
// - bank register picks R0..R7 within the selected register bank
// - indirect operands use R0 or R1 as address; moves take 2 cycles
// - bit operands address one bit in data RAM or special-function space
// - two-byte conditional jumps take 2 cycles, or 3 when taken
// - bit jumps take 3 or 4 cycles; clear variant clears bit on jump
// - compare jump takes 4/5 for direct and indirect, 3/4 otherwise
// - page call/jump, short and indirect jump 3; long 4; returns 5
// - code reads into accumulator are one byte, 3 cycles
// - external data ops take 3 cycles, 8-bit or 16-bit address
// - loading the data pointer immediate is three bytes, 3 cycles
// - direct to direct move is three bytes, 3 cycles
// - push and pop of a direct byte are two bytes, 2 cycles
// - nibble exchange swaps only low nibbles, in 2 cycles
// - accumulator clear, complement, rotates and swap take 1 cycle
// - carry logic with direct bits takes 2 cycles
// - register exchange and register moves with accumulator take 1 cycle
// - data pointer is low byte at 0x82 and high byte at 0x83
// - a branch not taken finishes one cycle before a taken one
// - stack pointer increments before push stores, resets to 0x07
package mitd_pkg;
    localparam logic [7:0] MITD_ADDR_DP_LOW = 8'h82;
    localparam logic [7:0] MITD_ADDR_DP_HIGH = 8'h83;
    localparam logic [7:0] MITD_ADDR_STACK = 8'h81;
    localparam logic [7:0] MITD_RST_DP = 8'h00;
    localparam logic [7:0] MITD_RST_STACK = 8'h07;
    localparam logic [7:0] MITD_SFR_BASE = 8'h80;
    localparam logic [7:0] MITD_SPARE_OP = 8'ha5;
    localparam int MITD_PAGE_BITS = 11;
    localparam int MITD_BANK_POS = 3;

    typedef enum logic [3:0] {
        MITD_K_PLAIN = 4'h0,
        MITD_K_COND = 4'h1,
        MITD_K_REL = 4'h2,
        MITD_K_PAGE = 4'h3,
        MITD_K_LONG = 4'h4,
        MITD_K_RET = 4'h5,
        MITD_K_DPJMP = 4'h6,
        MITD_K_DPLOAD = 4'h7,
        MITD_K_PUSH = 4'h8,
        MITD_K_POP = 4'h9,
        MITD_K_BITCLR = 4'ha
    } mitd_kind_t;

    typedef enum logic [1:0] {
        MITD_S_FETCH = 2'b00,
        MITD_S_OPER = 2'b01,
        MITD_S_WAIT = 2'b10
    } mitd_state_t;
endpackage

//--- verilog/mitd_decode.sv
// opcode table: bytes, cycle counts and instruction kind
// assumes a purely combinational use by the sequencer
`timescale 1ns/1ps
module mitd_decode (
    input wire logic [7:0] opcode,
    output logic [1:0] n_bytes,
    output logic [2:0] cyc_base,
    output mitd_pkg::mitd_kind_t kind,
    output logic uses_bank,
    output logic uses_ind
);
    always_comb begin
        n_bytes = 2'd1;
        cyc_base = 3'd1;
        kind = mitd_pkg::MITD_K_PLAIN;
        uses_bank = (opcode[3] == 1'b1);
        uses_ind = (opcode[3:1] == 3'b011);
        if (opcode[3:0] == 4'h1) begin
            n_bytes = 2'd2;
            cyc_base = 3'd3;
            kind = mitd_pkg::MITD_K_PAGE;
        end else begin
            case (opcode)
                8'h00, mitd_pkg::MITD_SPARE_OP: begin
                    cyc_base = 3'd1;
                end
                8'he4, 8'hf4, 8'h23, 8'h33, 8'h03, 8'h13, 8'hc4: begin
                    cyc_base = 3'd1;
                end
                8'h02, 8'h12: begin
                    n_bytes = 2'd3;
                    cyc_base = 3'd4;
                    kind = mitd_pkg::MITD_K_LONG;
                end
                8'h22, 8'h32: begin
                    cyc_base = 3'd5;
                    kind = mitd_pkg::MITD_K_RET;
                end
                8'h80: begin
                    n_bytes = 2'd2;
                    cyc_base = 3'd3;
                    kind = mitd_pkg::MITD_K_REL;
                end
                8'h73: begin
                    cyc_base = 3'd3;
                    kind = mitd_pkg::MITD_K_DPJMP;
                end
                8'h40, 8'h50, 8'h60, 8'h70: begin
                    n_bytes = 2'd2;
                    cyc_base = 3'd2;
                    kind = mitd_pkg::MITD_K_COND;
                end
                8'h20, 8'h30, 8'h10: begin
                    n_bytes = 2'd3;
                    cyc_base = 3'd3;
                    kind = (opcode == 8'h10) ? mitd_pkg::MITD_K_BITCLR
                                             : mitd_pkg::MITD_K_COND;
                end
                8'hb5, 8'hb6, 8'hb7: begin
                    n_bytes = 2'd3;
                    cyc_base = 3'd4;
                    kind = mitd_pkg::MITD_K_COND;
                end
                8'hb4, 8'hb8, 8'hb9, 8'hba, 8'hbb, 8'hbc, 8'hbd, 8'hbe,
                8'hbf: begin
                    n_bytes = 2'd3;
                    cyc_base = 3'd3;
                    kind = mitd_pkg::MITD_K_COND;
                end
                8'hd8, 8'hd9, 8'hda, 8'hdb, 8'hdc, 8'hdd, 8'hde, 8'hdf: begin
                    n_bytes = 2'd2;
                    cyc_base = 3'd2;
                    kind = mitd_pkg::MITD_K_COND;
                end
                8'hd5: begin
                    n_bytes = 2'd3;
                    cyc_base = 3'd3;
                    kind = mitd_pkg::MITD_K_COND;
                end
                8'h93, 8'h83, 8'he0, 8'hf0, 8'he2, 8'he3, 8'hf2, 8'hf3:
                begin
                    cyc_base = 3'd3;
                end
                8'h90: begin
                    n_bytes = 2'd3;
                    cyc_base = 3'd3;
                    kind = mitd_pkg::MITD_K_DPLOAD;
                end
                8'h85, 8'h75, 8'h43, 8'h53, 8'h63: begin
                    n_bytes = 2'd3;
                    cyc_base = 3'd3;
                end
                8'hc0, 8'hd0: begin
                    n_bytes = 2'd2;
                    cyc_base = 3'd2;
                    kind = (opcode == 8'hc0) ? mitd_pkg::MITD_K_PUSH
                                             : mitd_pkg::MITD_K_POP;
                end
                8'hd6, 8'hd7, 8'he6, 8'he7, 8'hf6, 8'hf7, 8'hc6,
                8'hc7: begin
                    cyc_base = 3'd2;
                end
                // immediate, direct-to-register and indirect-with-byte forms
                8'h24, 8'h34, 8'h44, 8'h54, 8'h64, 8'h74, 8'h94, 8'h76,
                8'h77, 8'h86, 8'h87, 8'ha6, 8'ha7, 8'h78, 8'h79, 8'h7a,
                8'h7b, 8'h7c, 8'h7d, 8'h7e, 8'h7f, 8'h88, 8'h89, 8'h8a,
                8'h8b, 8'h8c, 8'h8d, 8'h8e, 8'h8f, 8'ha8, 8'ha9, 8'haa,
                8'hab, 8'hac, 8'had, 8'hae, 8'haf: begin
                    n_bytes = 2'd2;
                    cyc_base = 3'd2;
                end
                // carry set, clear, complement and pointer increment
                8'hc3, 8'hd3, 8'hb3, 8'ha3: begin
                    cyc_base = 3'd1;
                end
                8'ha2, 8'h92, 8'h82, 8'hb0, 8'h72, 8'ha0, 8'hc2, 8'hd2,
                8'hb2: begin
                    n_bytes = 2'd2;
                    cyc_base = 3'd2;
                end
                // opcode 0xa4 takes 4 cycles, timed here within the 3-bit cycle counter
                8'ha4: cyc_base = 3'd4;
                default: begin
                    // register and accumulator forms take 1 cycle, indirect forms 2, others two bytes in 2
                    if (opcode[3] || opcode[3:0] == 4'h4) begin
                        cyc_base = 3'd1;
                    end else if (opcode[3:1] == 3'b011) begin
                        cyc_base = 3'd2;
                    end else begin
                        n_bytes = 2'd2;
                        cyc_base = 3'd2;
                    end
                end
            endcase
        end
    end
endmodule // mitd_decode

//--- verilog/mitd_target.sv
// branch target calculator for relative, page and long forms
// assumes next_pc is the address of the following instruction
`timescale 1ns/1ps
module mitd_target (
    input wire logic [15:0] next_pc,
    input wire logic [7:0] rel_off,
    input wire logic [10:0] page_bits,
    input wire logic [15:0] long_addr,
    output logic [15:0] rel_target,
    output logic [15:0] page_target,
    output logic [15:0] long_target
);
    always_comb begin
        rel_target = next_pc + {{8{rel_off[7]}}, rel_off};
        page_target = {next_pc[15:mitd_pkg::MITD_PAGE_BITS],
                       page_bits};
        long_target = long_addr;
    end
endmodule // mitd_target

//--- testbench/mitd_core_assertions.sv
// port checker for the instruction timing core
// assumes one clock domain and a synchronous active-low reset
`timescale 1ns/1ps
module mitd_core_assertions (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic sfr_wr,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    input wire logic [15:0] data_pointer16,
    input wire logic [7:0] stack_pointer,
    input wire logic instr_done,
    input wire logic [7:0] ram_addr,
    input wire logic ram_sel,
    input wire logic sfr_sel,
    input wire logic bit_clear
);
    logic [3:0] gap_r;
    logic [3:0] gap_nxt;
    // cycles since the previous completion, saturating
    always_comb begin
        gap_nxt = gap_r;
        if (instr_done) begin
            gap_nxt = 4'h1;
        end else if (gap_r != 4'hf) begin
            gap_nxt = gap_r + 4'h1;
        end
    end
    always_ff @(posedge core_clk) begin
        gap_r <= nrst ? gap_nxt : 4'h0;
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);
    done_pulse_a: assert property (instr_done |=> !instr_done)
        else $error("completion pulse longer than one cycle");
    gap_span_a: assert property (instr_done |-> gap_r inside {[2:10]})
        else $error("instruction interval out of range");
    dp_low_wr_a: assert property (sfr_wr && sfr_addr == 8'h82
        |=> data_pointer16[7:0] == $past(sfr_wdata))
        else $error("low data pointer write lost");
    dp_high_wr_a: assert property (sfr_wr && sfr_addr == 8'h83
        |=> data_pointer16[15:8] == $past(sfr_wdata))
        else $error("high data pointer write lost");
    dp_read_a: assert property (sfr_addr == 8'h82
        |=> sfr_rdata == $past(data_pointer16[7:0]))
        else $error("low data pointer read wrong");
    unmapped_read_a: assert property (
        !(sfr_addr inside {8'h81, 8'h82, 8'h83}) |=> sfr_rdata == 8'h00)
        else $error("unmapped read not zero");
    space_select_a: assert property (
        !(ram_sel && sfr_sel) && (!sfr_sel || ram_addr[7]))
        else $error("operand space select wrong");
    sp_step_a: assert property (
        !$past(sfr_wr) && $changed(stack_pointer) |->
        (stack_pointer - $past(stack_pointer)) inside
        {8'h01, 8'hff, 8'h02, 8'hfe})
        else $error("stack pointer step wrong");
    clear_pulse_a: assert property (bit_clear |=> !bit_clear)
        else $error("bit clear pulse too long");
endmodule // mitd_core_assertions

bind mitd_core mitd_core_assertions u_mitd_core_assertions (
    .core_clk(core_clk), .nrst(nrst), .sfr_wr(sfr_wr),
    .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .data_pointer16(data_pointer16), .stack_pointer(stack_pointer),
    .instr_done(instr_done), .ram_addr(ram_addr), .ram_sel(ram_sel),
    .sfr_sel(sfr_sel), .bit_clear(bit_clear));

//--- testbench/mitd_code_model.sv
// program memory model on the code fetch port
// assumes bytes settle in the cycle their address is shown
`timescale 1ns/1ps
module mitd_code_model (
    input wire logic [15:0] code_addr,
    output logic [7:0] code_data
);
    logic [7:0] mem [0:65535];
    // unused space holds no-operations
    initial begin
        for (int i = 0; i < 65536; i++) begin
            mem[i] = 8'h00;
        end
    end
    assign code_data = mem[code_addr];
endmodule // mitd_code_model

//--- testbench/mitd_core_bench.sv
// self-checking bench for the instruction timing core
// assumes the code model and the bound port checker
`timescale 1ns/1ps
module mitd_core_bench;
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    logic [7:0] code_data;
    logic branch_cond = 1'b0;
    logic [1:0] bank_select = 2'b10;
    logic [7:0] ind_reg_value = 8'h45;
    logic sfr_wr = 1'b0;
    logic [7:0] sfr_addr = 8'h00;
    logic [7:0] sfr_wdata = 8'h00;
    logic [15:0] code_addr;
    logic [7:0] sfr_rdata;
    logic [15:0] data_pointer16;
    logic [7:0] stack_pointer;
    logic [7:0] opcode_out;
    logic instr_done;
    logic [7:0] ram_addr;
    logic ram_sel;
    logic sfr_sel;
    logic bit_clear;
    logic [7:0] bit_addr;
    logic clr_seen = 1'b0;
    int fail_count = 0;
    int n_tests = 0;
    int n;

    mitd_code_model u_mitd_code_model (.code_addr(code_addr),
        .code_data(code_data));
    mitd_core u_mitd_core (.core_clk(core_clk), .nrst(nrst),
        .code_data(code_data), .branch_cond(branch_cond),
        .bank_select(bank_select), .ind_reg_value(ind_reg_value),
        .sfr_wr(sfr_wr), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
        .code_addr(code_addr), .sfr_rdata(sfr_rdata),
        .data_pointer16(data_pointer16), .stack_pointer(stack_pointer),
        .opcode_out(opcode_out), .instr_done(instr_done),
        .ram_addr(ram_addr), .ram_sel(ram_sel), .sfr_sel(sfr_sel),
        .bit_clear(bit_clear), .bit_addr(bit_addr));

    initial begin
        forever #10 core_clk = ~core_clk;
    end
    // records any clear pulse; read only at a later negedge
    always @(negedge core_clk) begin
        if (bit_clear === 1'b1) begin
            clr_seen <= 1'b1;
        end
    end

    task automatic close_out();
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic check(string what, logic [15:0] exp, logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic put(logic [15:0] a, logic [23:0] b, int nb);
        for (int i = 0; i < nb; i++) begin
            u_mitd_code_model.mem[a + 16'(i)] = b[8 * (nb - 1 - i) +: 8];
        end
    endtask
    task automatic sfr_write(logic [7:0] a, logic [7:0] d);
        @(negedge core_clk);
        sfr_wr = 1'b1;
        sfr_addr = a;
        sfr_wdata = d;
        @(negedge core_clk);
        sfr_wr = 1'b0;
    endtask
    task automatic sfr_read(logic [7:0] a, logic [7:0] exp);
        @(negedge core_clk);
        sfr_addr = a;
        @(negedge core_clk);
        check("sfr_rdata", {8'h00, exp}, {8'h00, sfr_rdata});
    endtask
    task automatic wait_done(output int cnt);
        cnt = 0;
        do begin
            @(negedge core_clk);
            cnt++;
        end while (instr_done !== 1'b1 && cnt < 40);
        if (cnt >= 40) begin
            fail_count++;
            close_out();
        end
    endtask
    // cond level, listed cycles, next address (ffff skips), stack
    // interval is the listed count plus fetch and operand turnaround
    task automatic step(logic c, int cyc, logic [15:0] pc, logic [7:0] sp);
        int k;
        branch_cond = c;
        wait_done(k);
        check("interval", 16'(cyc + 2), 16'(k));
        if (pc !== 16'hffff) begin
            check("code_addr", pc, code_addr);
        end
        check("stack_pointer", {8'h00, sp}, {8'h00, stack_pointer});
    endtask

    initial begin
        repeat (2) @(negedge core_clk);
        nrst = 1'b1;
        sfr_read(8'h82, 8'h00);
        sfr_read(8'h83, 8'h00);
        sfr_read(8'h81, 8'h07);
        sfr_read(8'h84, 8'h00);
        sfr_write(8'h82, 8'h5a);
        sfr_write(8'h83, 8'hc3);
        sfr_write(8'h90, 8'h11);
        sfr_read(8'h82, 8'h5a);
        sfr_read(8'h83, 8'hc3);
        sfr_read(8'h90, 8'h00);
        check("data_pointer16", 16'hc35a, data_pointer16);
        sfr_addr = 8'h00;
        nrst = 1'b0;
        put(16'h0001, 24'h0000a5, 1);
        put(16'h0002, 24'h00e4e8, 2);
        put(16'h0004, 24'he693e2, 3);
        put(16'h0007, 24'h901234, 3);
        put(16'h000a, 24'h859030, 3);
        put(16'h000d, 24'hc040d6, 3);
        put(16'h0010, 24'ha22040, 3);
        put(16'h0013, 24'h058002, 3);
        put(16'h0018, 24'h020100, 3);
        put(16'h0100, 24'h002180, 2);
        put(16'h0180, 24'hb40510, 3);
        put(16'h0193, 24'h1022f0, 3);
        put(16'h0186, 24'hb53003, 3);
        put(16'h0189, 24'h120040, 3);
        put(16'h0040, 24'h600222, 3);
        put(16'h0044, 24'h000022, 1);
        repeat (2) @(negedge core_clk);
        check("data_pointer16", 16'h0000, data_pointer16);
        nrst = 1'b1;
        wait_done(n);
        step(1'b0, 1, 16'h0002, 8'h07);
        check("opcode_out", 16'h00a5, {8'h00, opcode_out});
        step(1'b0, 1, 16'h0003, 8'h07);
        step(1'b0, 1, 16'h0004, 8'h07);
        check("ram_addr", 16'h0010, {8'h00, ram_addr});
        step(1'b0, 2, 16'h0005, 8'h07);
        check("ram_addr", 16'h0045, {8'h00, ram_addr});
        step(1'b0, 3, 16'h0006, 8'h07);
        step(1'b0, 3, 16'h0007, 8'h07);
        step(1'b0, 3, 16'h000a, 8'h07);
        check("data_pointer16", 16'h1234, data_pointer16);
        step(1'b0, 3, 16'h000d, 8'h07);
        check("space", 16'h0001, {14'h0, ram_sel, sfr_sel});
        check("ram_addr", 16'h0090, {8'h00, ram_addr});
        step(1'b0, 2, 16'h000f, 8'h08);
        step(1'b0, 2, 16'h0010, 8'h08);
        step(1'b0, 2, 16'h0012, 8'h08);
        step(1'b0, 2, 16'h0014, 8'h08);
        step(1'b0, 3, 16'h0018, 8'h08);
        step(1'b0, 4, 16'h0100, 8'h08);
        step(1'b0, 3, 16'h0180, 8'h08);
        step(1'b1, 4, 16'h0193, 8'h08);
        check("bit_clear", 16'h0000, {15'h0, clr_seen});
        step(1'b1, 4, 16'h0186, 8'h08);
        check("bit_clear", 16'h0001, {15'h0, bit_clear});
        check("bit_addr", 16'h0022, {8'h00, bit_addr});
        step(1'b0, 4, 16'h0189, 8'h08);
        check("clr_seen", 16'h0001, {15'h0, clr_seen});
        step(1'b0, 4, 16'h0040, 8'h0a);
        step(1'b1, 3, 16'h0044, 8'h0a);
        step(1'b0, 5, 16'hffff, 8'h08);
        close_out();
    end
endmodule // mitd_core_bench
